// >>> hirs_pkg.sv
// Package with register map, field positions and reset values of the host interrupt block.
package hirs_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h02;
  localparam logic [7:0] IDX_RX_STATUS = 8'h04;
  localparam logic [7:0] IDX_RX_CTRL = 8'h08;
  localparam logic [9:0] ADDR_IRQ_ENABLE = {IDX_IRQ_ENABLE, 2'b00};
  localparam logic [9:0] ADDR_IRQ_FLAGS = {IDX_IRQ_FLAGS, 2'b00};
  localparam logic [9:0] ADDR_RX_STATUS = {IDX_RX_STATUS, 2'b00};
  localparam logic [9:0] ADDR_RX_CTRL = {IDX_RX_CTRL, 2'b00};

  // Interrupt flag and enable bit positions.
  localparam int BIT_LINK_CHANGE = 15;
  localparam int BIT_TX_DONE = 14;
  localparam int BIT_RX_FRAME = 13;
  localparam int BIT_RX_OVERRUN = 11;
  localparam int BIT_TX_HALTED = 9;
  localparam int BIT_RX_HALTED = 8;
  localparam int BIT_RX_ERR_FRAME = 7;
  localparam logic [15:0] FLAG_MASK = 16'heb80;
  localparam logic [15:0] FLAGS_RESET = 16'h0300;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;

  // Receive status word field positions.
  localparam int RXS_VALID = 15;
  localparam int RXS_PORT_HI = 9;
  localparam int RXS_PORT_LO = 8;
  localparam int RXS_BCAST = 7;
  localparam int RXS_GROUP = 6;
  localparam int RXS_UCAST = 5;
  localparam int RXS_TYPE = 3;
  localparam int RXS_TOO_LONG = 2;
  localparam int RXS_RUNT = 1;
  localparam int RXS_CRC = 0;
  localparam logic [1:0] PORT_ONE = 2'b01;
  localparam logic [1:0] PORT_TWO = 2'b10;

  // Receive control register.
  localparam int RXC_PASS_BAD = 9;
  localparam logic [15:0] RX_CTRL_MASK = 16'h0200;
  localparam logic [15:0] RX_CTRL_RESET = 16'h0000;

  // Frame classification thresholds in bytes, broadcast address and group bit position.
  localparam logic [15:0] TYPE_LEN_MAX = 16'd1500;
  localparam logic [15:0] FRAME_LEN_MAX = 16'd1916;
  localparam logic [47:0] BCAST_ADDR = 48'hffff_ffff_ffff;
  localparam int DA_GROUP_BIT = 40;

endpackage : hirs_pkg

// >>> hirs_top.sv
// Interrupt flags, enables and current receive frame status behind an APB slave.
`timescale 1ns/1ps

module hirs_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events from MAC and queue manager, same clock
  input wire logic link_up,
  input wire logic tx_frame_sent,
  input wire logic transmit_queue_has_room,
  input wire logic rx_frame_stored,
  input wire logic rx_overrun,
  input wire logic tx_halted,
  input wire logic rx_halted,
  input wire logic rx_error_frame,
  // Frame at the head of the receive queue
  input wire logic head_present,
  input wire logic head_complete,
  input wire logic [1:0] head_port,
  input wire logic [47:0] head_dest_addr,
  input wire logic [15:0] head_len_type,
  input wire logic [15:0] head_byte_len,
  input wire logic head_runt,
  input wire logic head_crc_error,
  // Outputs to host and queue manager
  output logic irq,
  output logic head_discard
);

  // Register state.
  logic [15:0] flags;
  logic [15:0] enables;
  logic [15:0] rx_ctrl;
  logic [15:0] rx_status;
  logic link_prev;
  logic link_seen;
  logic tx_sent_pend;
  logic [15:0] next_flags;
  logic [15:0] next_enables;
  logic [15:0] next_rx_ctrl;
  logic [15:0] next_rx_status;
  logic next_link_prev;
  logic next_link_seen;
  logic next_tx_sent_pend;
  logic next_irq;
  logic next_head_discard;

  // Bus state.
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // Decoded bus access.
  logic access;
  logic wr_commit;
  logic mapped;
  logic [15:0] wr_mask;
  logic [15:0] wr_val;

  // Frame classification.
  logic is_bcast;
  logic is_group;
  logic port_ok;
  logic too_long;
  logic is_bad;
  logic withhold;
  logic [15:0] set_vec;
  logic [15:0] clear_vec;
  // Flag cells and their next values.
  logic link_change_flag;
  logic transmit_done_flag;
  logic frame_received_flag;
  logic receive_overrun_flag;
  logic transmit_halted_flag;
  logic receive_halted_flag;
  logic receive_error_frame_flag;
  logic next_link_change_flag;
  logic next_transmit_done_flag;
  logic next_frame_received_flag;
  logic next_receive_overrun_flag;
  logic next_transmit_halted_flag;
  logic next_receive_halted_flag;
  logic next_receive_error_frame_flag;

  // The slave answers with one wait state so that every response signal is a flop.
  always_comb begin
    access = psel && penable && !pready;
    mapped = (paddr[11:10] == 2'b00) &&
             ((paddr[9:2] == hirs_pkg::IDX_IRQ_ENABLE) ||
              (paddr[9:2] == hirs_pkg::IDX_IRQ_FLAGS) ||
              (paddr[9:2] == hirs_pkg::IDX_RX_STATUS) ||
              (paddr[9:2] == hirs_pkg::IDX_RX_CTRL));
    wr_commit = psel && penable && pready && pwrite && mapped;
    wr_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    wr_val = pwdata[15:0] & wr_mask;
  end

  always_comb begin
    next_pready = access;
    next_pslverr = access && !mapped;
    next_prdata = 32'h0000_0000;
    if (access && mapped) begin
      unique case (paddr[9:2])
        hirs_pkg::IDX_IRQ_ENABLE: next_prdata = {16'h0000, enables};
        hirs_pkg::IDX_IRQ_FLAGS: next_prdata = {16'h0000, flags};
        hirs_pkg::IDX_RX_STATUS: next_prdata = {16'h0000, rx_status};
        hirs_pkg::IDX_RX_CTRL: next_prdata = {16'h0000, rx_ctrl};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // Frame classification from the head-of-queue descriptor.
  always_comb begin
    is_bcast = (head_dest_addr == hirs_pkg::BCAST_ADDR);
    is_group = head_dest_addr[hirs_pkg::DA_GROUP_BIT];
    port_ok = (head_port == hirs_pkg::PORT_ONE) || (head_port == hirs_pkg::PORT_TWO);
    too_long = (head_byte_len > hirs_pkg::FRAME_LEN_MAX);
    is_bad = too_long || head_runt || head_crc_error;
    withhold = is_bad && !rx_ctrl[hirs_pkg::RXC_PASS_BAD];
  end

  // The status word is rebuilt every cycle so it always tracks the head frame.
  always_comb begin
    next_rx_status = 16'h0000;
    next_head_discard = head_present && head_complete && withhold;
    if (head_present && head_complete && !withhold) begin
      next_rx_status[hirs_pkg::RXS_VALID] = port_ok;
      next_rx_status[hirs_pkg::RXS_PORT_HI:hirs_pkg::RXS_PORT_LO] = head_port;
      next_rx_status[hirs_pkg::RXS_BCAST] = is_bcast;
      next_rx_status[hirs_pkg::RXS_GROUP] = is_group || is_bcast;
      next_rx_status[hirs_pkg::RXS_UCAST] = !is_group && !is_bcast;
      // The type indication has no meaning for a runt, so it is held low there.
      next_rx_status[hirs_pkg::RXS_TYPE] = !head_runt &&
                                           (head_len_type > hirs_pkg::TYPE_LEN_MAX);
      // Oversize frames are flagged, or discarded while RXC_PASS_BAD is clear; their length is never cut here.
      next_rx_status[hirs_pkg::RXS_TOO_LONG] = too_long;
      next_rx_status[hirs_pkg::RXS_RUNT] = head_runt;
      next_rx_status[hirs_pkg::RXS_CRC] = head_crc_error;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_status <= 16'h0000;
      head_discard <= 1'b0;
    end else begin
      rx_status <= next_rx_status;
      head_discard <= next_head_discard;
    end
  end

  // Event detection, flag latching and write-one-to-clear.
  always_comb begin
    next_link_prev = link_up;
    next_link_seen = 1'b1;
    next_tx_sent_pend = tx_sent_pend || tx_frame_sent;
    set_vec = 16'h0000;
    clear_vec = 16'h0000;
    // The first sample after reset only primes the detector, to avoid a false change.
    set_vec[hirs_pkg::BIT_LINK_CHANGE] = link_seen && (link_up != link_prev);
    if (next_tx_sent_pend && transmit_queue_has_room) begin
      set_vec[hirs_pkg::BIT_TX_DONE] = 1'b1;
      next_tx_sent_pend = 1'b0;
    end
    set_vec[hirs_pkg::BIT_RX_FRAME] = rx_frame_stored;
    set_vec[hirs_pkg::BIT_RX_OVERRUN] = rx_overrun;
    set_vec[hirs_pkg::BIT_TX_HALTED] = tx_halted;
    set_vec[hirs_pkg::BIT_RX_HALTED] = rx_halted;
    set_vec[hirs_pkg::BIT_RX_ERR_FRAME] = rx_error_frame;
    next_enables = enables;
    next_rx_ctrl = rx_ctrl;
    if (wr_commit) begin
      unique case (paddr[9:2])
        hirs_pkg::IDX_IRQ_FLAGS: begin
          clear_vec = wr_val & hirs_pkg::FLAG_MASK;
        end
        hirs_pkg::IDX_IRQ_ENABLE: begin
          next_enables = ((enables & ~wr_mask) | wr_val) & hirs_pkg::FLAG_MASK;
        end
        hirs_pkg::IDX_RX_CTRL: begin
          next_rx_ctrl = ((rx_ctrl & ~wr_mask) | wr_val) & hirs_pkg::RX_CTRL_MASK;
        end
        default: begin
          clear_vec = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enables <= hirs_pkg::ENABLE_RESET;
      rx_ctrl <= hirs_pkg::RX_CTRL_RESET;
      link_prev <= 1'b0;
      link_seen <= 1'b0;
      tx_sent_pend <= 1'b0;
      irq <= 1'b0;
    end else begin
      enables <= next_enables;
      rx_ctrl <= next_rx_ctrl;
      link_prev <= next_link_prev;
      link_seen <= next_link_seen;
      tx_sent_pend <= next_tx_sent_pend;
      irq <= next_irq;
    end
  end

  // Flag word as software sees it; enables do not gate latching.
  always_comb begin
    flags = 16'h0000;
    flags[hirs_pkg::BIT_LINK_CHANGE] = link_change_flag;
    flags[hirs_pkg::BIT_TX_DONE] = transmit_done_flag;
    flags[hirs_pkg::BIT_RX_FRAME] = frame_received_flag;
    flags[hirs_pkg::BIT_RX_OVERRUN] = receive_overrun_flag;
    flags[hirs_pkg::BIT_TX_HALTED] = transmit_halted_flag;
    flags[hirs_pkg::BIT_RX_HALTED] = receive_halted_flag;
    flags[hirs_pkg::BIT_RX_ERR_FRAME] = receive_error_frame_flag;
    next_flags = 16'h0000;
    next_flags[hirs_pkg::BIT_LINK_CHANGE] = next_link_change_flag;
    next_flags[hirs_pkg::BIT_TX_DONE] = next_transmit_done_flag;
    next_flags[hirs_pkg::BIT_RX_FRAME] = next_frame_received_flag;
    next_flags[hirs_pkg::BIT_RX_OVERRUN] = next_receive_overrun_flag;
    next_flags[hirs_pkg::BIT_TX_HALTED] = next_transmit_halted_flag;
    next_flags[hirs_pkg::BIT_RX_HALTED] = next_receive_halted_flag;
    next_flags[hirs_pkg::BIT_RX_ERR_FRAME] = next_receive_error_frame_flag;
    next_irq = |(next_flags & next_enables);
  end

  // One cell per documented flag; reserved positions have no storage at all.
  hirs_flag_cell #(
    .RESET_VAL(hirs_pkg::FLAGS_RESET[hirs_pkg::BIT_LINK_CHANGE])
  ) link_change_cell (
    .clk(clk),
    .rst_n(rst_n),
    .set_event(set_vec[hirs_pkg::BIT_LINK_CHANGE]),
    .clear_req(clear_vec[hirs_pkg::BIT_LINK_CHANGE]),
    .flag(link_change_flag),
    .next_flag(next_link_change_flag)
  );

  hirs_flag_cell #(
    .RESET_VAL(hirs_pkg::FLAGS_RESET[hirs_pkg::BIT_TX_DONE])
  ) transmit_done_cell (
    .clk(clk),
    .rst_n(rst_n),
    .set_event(set_vec[hirs_pkg::BIT_TX_DONE]),
    .clear_req(clear_vec[hirs_pkg::BIT_TX_DONE]),
    .flag(transmit_done_flag),
    .next_flag(next_transmit_done_flag)
  );

  hirs_flag_cell #(
    .RESET_VAL(hirs_pkg::FLAGS_RESET[hirs_pkg::BIT_RX_FRAME])
  ) frame_received_cell (
    .clk(clk),
    .rst_n(rst_n),
    .set_event(set_vec[hirs_pkg::BIT_RX_FRAME]),
    .clear_req(clear_vec[hirs_pkg::BIT_RX_FRAME]),
    .flag(frame_received_flag),
    .next_flag(next_frame_received_flag)
  );

  hirs_flag_cell #(
    .RESET_VAL(hirs_pkg::FLAGS_RESET[hirs_pkg::BIT_RX_OVERRUN])
  ) receive_overrun_cell (
    .clk(clk),
    .rst_n(rst_n),
    .set_event(set_vec[hirs_pkg::BIT_RX_OVERRUN]),
    .clear_req(clear_vec[hirs_pkg::BIT_RX_OVERRUN]),
    .flag(receive_overrun_flag),
    .next_flag(next_receive_overrun_flag)
  );

  hirs_flag_cell #(
    .RESET_VAL(hirs_pkg::FLAGS_RESET[hirs_pkg::BIT_TX_HALTED])
  ) transmit_halted_cell (
    .clk(clk),
    .rst_n(rst_n),
    .set_event(set_vec[hirs_pkg::BIT_TX_HALTED]),
    .clear_req(clear_vec[hirs_pkg::BIT_TX_HALTED]),
    .flag(transmit_halted_flag),
    .next_flag(next_transmit_halted_flag)
  );

  hirs_flag_cell #(
    .RESET_VAL(hirs_pkg::FLAGS_RESET[hirs_pkg::BIT_RX_HALTED])
  ) receive_halted_cell (
    .clk(clk),
    .rst_n(rst_n),
    .set_event(set_vec[hirs_pkg::BIT_RX_HALTED]),
    .clear_req(clear_vec[hirs_pkg::BIT_RX_HALTED]),
    .flag(receive_halted_flag),
    .next_flag(next_receive_halted_flag)
  );

  hirs_flag_cell #(
    .RESET_VAL(hirs_pkg::FLAGS_RESET[hirs_pkg::BIT_RX_ERR_FRAME])
  ) receive_error_frame_cell (
    .clk(clk),
    .rst_n(rst_n),
    .set_event(set_vec[hirs_pkg::BIT_RX_ERR_FRAME]),
    .clear_req(clear_vec[hirs_pkg::BIT_RX_ERR_FRAME]),
    .flag(receive_error_frame_flag),
    .next_flag(next_receive_error_frame_flag)
  );

endmodule : hirs_top

// One event flag: set by its event, cleared by a one written to its position.
module hirs_flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Set and clear requests
  input wire logic set_event,
  input wire logic clear_req,
  // Flag state
  output logic flag,
  output logic next_flag
);

  always_comb begin
    next_flag = flag;
    if (clear_req) begin
      next_flag = 1'b0;
    end
    // An event in the same cycle as its clear wins, so no occurrence is lost.
    if (set_event) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= RESET_VAL;
    end else begin
      flag <= next_flag;
    end
  end

endmodule : hirs_flag_cell

// >>> hirs_asserts.sv
// Checker with bus timing and interrupt properties of the host interrupt block.
`timescale 1ns/1ps
module hirs_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events and interrupt
  input wire logic link_up,
  input wire logic rx_overrun,
  input wire logic irq
);
  logic [15:0] en_q;
  logic [15:0] next_en_q;
  logic wr_en;
  logic mapped;
  assign wr_en = psel && penable && pready && pwrite && paddr[11:2] == 10'h000;
  assign mapped = paddr[11:2] inside {10'h000, 10'h002, 10'h004, 10'h008};
  // Shadow of the enable register, so interrupt timing can be judged from the pins.
  always_comb begin
    next_en_q = en_q;
    if (wr_en) begin
      next_en_q = pwdata[15:0] & hirs_pkg::FLAG_MASK;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 16'h0000;
    end else begin
      en_q <= next_en_q;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wait;
    penable && !pready;
  endsequence
  a_one_wait: assert property ($rose(penable) && psel |-> s_wait ##1 pready)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_irq_quiet: assert property (en_q == 16'h0000 && $past(en_q) == 16'h0000 |-> !irq)
    else $error("irq high with no enable");
  a_overrun_irq: assert property (rx_overrun && en_q[11] && !wr_en |=> irq)
    else $error("overrun did not raise irq");
  a_link_irq: assert property ($changed(link_up) && en_q[15] && !wr_en |=> irq)
    else $error("link change did not raise irq");
endmodule : hirs_asserts
bind hirs_top hirs_asserts chk (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .link_up, .rx_overrun, .irq);

// >>> hirs_mac_model.sv
// Model of the MAC and queue manager: event pulses and a table of head frames.
`timescale 1ns/1ps
module hirs_mac_model (
  // Clock, reset and test controls
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] ev,
  input wire logic [2:0] fsel,
  // Events
  output logic link_up,
  output logic tx_frame_sent,
  output logic transmit_queue_has_room,
  output logic rx_frame_stored,
  output logic rx_overrun,
  output logic tx_halted,
  output logic rx_halted,
  output logic rx_error_frame,
  // Head frame descriptor
  output logic head_present,
  output logic head_complete,
  output logic [1:0] head_port,
  output logic [47:0] head_dest_addr,
  output logic [15:0] head_len_type,
  output logic [15:0] head_byte_len,
  output logic head_runt,
  output logic head_crc_error
);
  logic next_link_up;
  assign next_link_up = link_up ^ ev[7];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_up <= 1'b0;
    end else begin
      link_up <= next_link_up;
    end
  end
  assign tx_frame_sent = ev[6];
  // Bit 0 stalls the queue, so a sent frame has to wait for room before it counts.
  assign transmit_queue_has_room = !ev[0];
  assign {rx_frame_stored, rx_overrun, tx_halted, rx_halted, rx_error_frame} = ev[5:1];
  // Frame 0 is an empty queue and frame 5 is still being received.
  always_comb begin
    head_present = fsel != 3'h0;
    head_complete = fsel != 3'h5;
    head_port = 2'b01;
    head_dest_addr = 48'hffff_ffff_ffff;
    head_len_type = 16'h0800;
    head_byte_len = 16'h0040;
    head_runt = 1'b0;
    head_crc_error = 1'b0;
    if (fsel == 3'h2 || fsel == 3'h4) begin
      head_port = 2'b10;
      head_dest_addr = 48'h0200_0000_0001;
      head_len_type = fsel == 3'h2 ? 16'h002e : 16'h0800;
      head_runt = fsel == 3'h4;
    end
    if (fsel == 3'h3) begin
      head_dest_addr = 48'h0100_5e00_0001;
      head_byte_len = 16'h07d0;
      head_crc_error = 1'b1;
    end
  end
endmodule : hirs_mac_model

// >>> testbench.sv
// Self-checking testbench of the host interrupt block.
`timescale 1ns/1ps
module testbench;
  localparam logic [11:0] A_EN = {2'b00, hirs_pkg::ADDR_IRQ_ENABLE};
  localparam logic [11:0] A_FL = {2'b00, hirs_pkg::ADDR_IRQ_FLAGS};
  localparam logic [11:0] A_RX = {2'b00, hirs_pkg::ADDR_RX_STATUS};
  localparam logic [11:0] A_RC = {2'b00, hirs_pkg::ADDR_RX_CTRL};
  localparam logic [15:0] FEXP [6] = '{16'h0, 16'h81c8, 16'h8220, 16'h814d, 16'h8222, 16'h0};
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] ev = 8'h00;
  logic [2:0] fsel = 3'h0;
  logic pready, pslverr, err, irq, head_discard, link_up, tx_frame_sent;
  logic transmit_queue_has_room;
  logic rx_frame_stored, rx_overrun, tx_halted, rx_halted, rx_error_frame;
  logic head_present, head_complete, head_runt, head_crc_error;
  logic [1:0] head_port;
  logic [47:0] head_dest_addr;
  logic [15:0] head_len_type, head_byte_len;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  always #2.5 clk = ~clk;
  hirs_top uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .link_up, .tx_frame_sent, .transmit_queue_has_room, .rx_frame_stored,
    .rx_overrun, .tx_halted, .rx_halted, .rx_error_frame, .head_present, .head_complete,
    .head_port, .head_dest_addr, .head_len_type, .head_byte_len, .head_runt,
    .head_crc_error, .irq, .head_discard);
  hirs_mac_model mac (.clk, .rst_n, .ev, .fsel, .link_up, .tx_frame_sent,
    .transmit_queue_has_room, .rx_frame_stored, .rx_overrun, .tx_halted, .rx_halted,
    .rx_error_frame, .head_present,
    .head_complete, .head_port, .head_dest_addr, .head_len_type, .head_byte_len,
    .head_runt, .head_crc_error);
  task automatic end_sim;
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // One transfer, then an idle cycle so back-to-back calls never drive a signal twice.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
    apb(1'b0, a, 16'h0000);
    check("read data", r, {16'h0000, exp});
  endtask : rd_chk
  task automatic fire(input logic [7:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
    @(posedge clk);
  endtask : fire
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(A_FL, 16'h0300);
    rd_chk(A_EN, 16'h0000);
    rd_chk(A_RX, 16'h0000);
    apb(1'b1, A_FL, 16'hffff);
    fire(8'hfe);
    rd_chk(A_FL, 16'heb80);
    rd_chk(A_FL, 16'heb80);
    apb(1'b1, A_FL, 16'h0000);
    rd_chk(A_FL, 16'heb80);
    apb(1'b1, A_FL, 16'h0800);
    rd_chk(A_FL, 16'he380);
    apb(1'b1, A_FL, 16'hffff);
    rd_chk(A_FL, 16'h0000);
    // A frame sent while the queue has no room must wait for room before it is flagged.
    ev <= 8'h41;
    @(posedge clk);
    ev <= 8'h01;
    rd_chk(A_FL, 16'h0000);
    fire(8'h00);
    rd_chk(A_FL, 16'h4000);
    apb(1'b1, A_FL, 16'hffff);
    check("irq idle", {31'h0, irq}, 32'h0);
    apb(1'b1, A_EN, 16'hffff);
    rd_chk(A_EN, 16'heb80);
    for (int i = 0; i < 2; i++) begin
      fire(i == 0 ? 8'h10 : 8'h80);
      // A link toggle reaches the detector one edge after the model flips the level.
      @(posedge clk);
      check("irq raised", {31'h0, irq}, 32'h1);
      apb(1'b1, A_FL, 16'hffff);
      check("irq cleared", {31'h0, irq}, 32'h0);
    end
    apb(1'b0, 12'h00c, 16'h0000);
    check("unmapped error", {31'h0, err}, 32'h1);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, A_RC, p == 1 ? 16'h0200 : 16'h0000);
      for (int f = 0; f < 6; f++) begin
        fsel <= f[2:0];
        rd_chk(A_RX, (p == 0 && f inside {3, 4}) ? 16'h0000 : FEXP[f]);
        check("discard", {31'h0, head_discard}, {31'h0, p == 0 && f inside {3, 4}});
      end
    end
    end_sim();
  end
endmodule : testbench
